//--- adcc_pkg.sv
package adcc_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_SAMP = 8'h08;
  localparam logic [7:0] ADDR_WINCTL = 8'h0c;
  localparam logic [7:0] ADDR_WINLO = 8'h10;
  localparam logic [7:0] ADDR_WINHI = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQEN = 8'h20;
  localparam logic [7:0] ADDR_IRQCLR = 8'h24;
  // field positions
  localparam int CTRL_TRIG_BIT = 0;
  localparam int CTRL_CAP_BIT = 1;
  localparam int SEL_MUX_LSB = 0;
  localparam int SEL_REF_LSB = 8;
  localparam int SAMP_DLY_LSB = 0;
  localparam int SAMP_LEN_LSB = 8;
  localparam int ST_RDY_BIT = 0;
  localparam int ST_WIN_BIT = 1;
  localparam int ST_BUSY_BIT = 8;
  // widths
  localparam int RES_W = 10;
  localparam int MUX_W = 5;
  localparam int REF_W = 3;
  localparam int DLY_W = 4;
  localparam int LEN_W = 5;
  localparam int CONV_CYCLES_W = 4;
  // timing: fixed sampling overhead and conversion length in converter cycles
  localparam logic [7:0] SAMP_BASE = 8'h02;
  localparam logic [CONV_CYCLES_W-1:0] CONV_CYCLES = 4'ha;
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] WIN_MODE_RESET = 2'h0;
  // window condition encoding
  typedef enum logic [2:0] {
    ADCC_WIN_NONE = 3'h0,
    ADCC_WIN_BELOW = 3'h1,
    ADCC_WIN_ABOVE = 3'h2,
    ADCC_WIN_INSIDE = 3'h3,
    ADCC_WIN_OUTSIDE = 3'h4
  } adcc_win_t;
endpackage

//--- adcc_window.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_window (
  // operands
  input wire logic [adcc_pkg::RES_W-1:0] result,
  input wire logic [adcc_pkg::RES_W-1:0] lower,
  input wire logic [adcc_pkg::RES_W-1:0] upper,
  input wire logic [2:0] mode,
  // verdict
  output logic hit
);
  // combinational condition select (below uses lower, above uses upper)
  always_comb begin
    unique case (mode)
      adcc_pkg::ADCC_WIN_BELOW: hit = result < lower;
      adcc_pkg::ADCC_WIN_ABOVE: hit = result > upper;
      adcc_pkg::ADCC_WIN_INSIDE: hit = (result > lower) && (result < upper);
      adcc_pkg::ADCC_WIN_OUTSIDE: hit = (result < lower) || (result > upper);
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- adcc_seq.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_seq (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic [7:0] samp_cycles,
  // status
  output logic busy,
  output logic sampling,
  output logic last,
  output logic done
);
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_t;
  adcc_state_t state_reg;
  logic [7:0] cnt_reg;

  // sampling then conversion countdown
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ADCC_IDLE;
      cnt_reg <= 8'h00;
    end else if (ce) begin
      unique case (state_reg)
        ADCC_IDLE: if (start) begin
          state_reg <= ADCC_SAMPLE;
          cnt_reg <= samp_cycles - 8'h01;
        end
        ADCC_SAMPLE: if (cnt_reg == 8'h00) begin
          state_reg <= ADCC_CONVERT;
          cnt_reg <= {4'h0, adcc_pkg::CONV_CYCLES} - 8'h01;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        ADCC_CONVERT: if (cnt_reg == 8'h00) begin
          state_reg <= ADCC_IDLE;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      endcase
    end
  end

  assign busy = (state_reg != ADCC_IDLE);
  assign sampling = (state_reg == ADCC_SAMPLE);
  assign last = (state_reg == ADCC_CONVERT) && (cnt_reg == 8'h00);
  assign done = last && ce;
endmodule
`default_nettype wire

//--- adcc_top.sv
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - result read or write-one clears ready flag
// - sampling lasts two plus delay plus length
// - selections copied from holding register when idle
// - selections frozen once conversion starts
// - copying resumes in last conversion cycle
// - conversion starts on next edge after trigger
// - four window conditions: below, above, inside, outside
// - thresholds and mode come from registers
// - window hit sets flag and requests interrupt
// - interrupt only when its enable bit set
module adcc_top (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // analog converter side
  input wire logic [adcc_pkg::RES_W-1:0] ADC_DATA,
  output logic [adcc_pkg::MUX_W-1:0] POSITIVE_INPUT_SELECT,
  output logic [adcc_pkg::REF_W-1:0] REFERENCE_SELECT,
  output logic SAMPLE_CAPACITANCE_SELECT,
  output logic SAMPLE_EN,
  // interrupt
  output logic IRQ
);
  logic [adcc_pkg::MUX_W-1:0] mux_hold_reg;
  logic [adcc_pkg::REF_W-1:0] ref_hold_reg;
  logic [adcc_pkg::MUX_W-1:0] mux_act_reg;
  logic [adcc_pkg::REF_W-1:0] ref_act_reg;
  logic cap_reg;
  logic [adcc_pkg::DLY_W-1:0] dly_reg;
  logic [adcc_pkg::LEN_W-1:0] len_reg;
  logic [2:0] wmode_reg;
  logic [adcc_pkg::RES_W-1:0] wlo_reg;
  logic [adcc_pkg::RES_W-1:0] whi_reg;
  logic [adcc_pkg::RES_W-1:0] res_reg;
  logic [1:0] flag_reg;
  logic [1:0] irqen_reg;
  logic trig_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic samp_en_reg;
  logic irq_reg;
  logic busy;
  logic sampling;
  logic last;
  logic done;
  logic hit;
  logic wr;
  logic rd;
  logic [7:0] samp_cycles;
  logic [1:0] set_vec;
  logic [1:0] clr_vec;

  // a bus access is taken once, answered the next cycle
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_reg && CE;
  assign rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_reg && CE;
  assign samp_cycles = adcc_pkg::SAMP_BASE + {4'h0, dly_reg} + {3'h0, len_reg};

  adcc_seq u_seq (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .start(trig_reg),
    .samp_cycles(samp_cycles),
    .busy(busy),
    .sampling(sampling),
    .last(last),
    .done(done)
  );

  adcc_window u_win (
    .result(ADC_DATA),
    .lower(wlo_reg),
    .upper(whi_reg),
    .mode(wmode_reg),
    .hit(hit)
  );

  // bus acknowledge, one cycle after the request is seen
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else if (CE) begin
      ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
    end
  end

  // trigger: a write of one starts conversion at the next edge
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      trig_reg <= 1'b0;
    end else if (CE) begin
      trig_reg <= wr && WB_ADR_I == adcc_pkg::ADDR_CTRL && WB_SEL_I[0]
        && WB_DAT_I[adcc_pkg::CTRL_TRIG_BIT] && !busy;
    end
  end

  // configuration registers written by software
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cap_reg <= 1'b0;
      mux_hold_reg <= '0;
      ref_hold_reg <= '0;
      dly_reg <= '0;
      len_reg <= '0;
      wmode_reg <= {1'b0, adcc_pkg::WIN_MODE_RESET};
      wlo_reg <= '0;
      whi_reg <= '0;
      irqen_reg <= 2'h0;
    end else if (wr) begin
      unique case (WB_ADR_I)
        adcc_pkg::ADDR_CTRL: if (WB_SEL_I[0]) begin
          cap_reg <= WB_DAT_I[adcc_pkg::CTRL_CAP_BIT];
        end
        adcc_pkg::ADDR_SEL: begin
          if (WB_SEL_I[0]) begin
            mux_hold_reg <= WB_DAT_I[adcc_pkg::SEL_MUX_LSB +: adcc_pkg::MUX_W];
          end
          if (WB_SEL_I[1]) begin
            ref_hold_reg <= WB_DAT_I[adcc_pkg::SEL_REF_LSB +: adcc_pkg::REF_W];
          end
        end
        adcc_pkg::ADDR_SAMP: begin
          if (WB_SEL_I[0]) begin
            dly_reg <= WB_DAT_I[adcc_pkg::SAMP_DLY_LSB +: adcc_pkg::DLY_W];
          end
          if (WB_SEL_I[1]) begin
            len_reg <= WB_DAT_I[adcc_pkg::SAMP_LEN_LSB +: adcc_pkg::LEN_W];
          end
        end
        adcc_pkg::ADDR_WINCTL: if (WB_SEL_I[0]) begin
          wmode_reg <= WB_DAT_I[2:0];
        end
        adcc_pkg::ADDR_WINLO: if (WB_SEL_I[0] && WB_SEL_I[1]) begin
          wlo_reg <= WB_DAT_I[adcc_pkg::RES_W-1:0];
        end
        adcc_pkg::ADDR_WINHI: if (WB_SEL_I[0] && WB_SEL_I[1]) begin
          whi_reg <= WB_DAT_I[adcc_pkg::RES_W-1:0];
        end
        adcc_pkg::ADDR_IRQEN: if (WB_SEL_I[0]) begin
          irqen_reg <= WB_DAT_I[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // active selection follows the holding register except while locked
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mux_act_reg <= '0;
      ref_act_reg <= '0;
    end else if (CE && (!busy || last) && !trig_reg) begin
      mux_act_reg <= mux_hold_reg;
      ref_act_reg <= ref_hold_reg;
    end
  end

  // result capture at the end of conversion
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      res_reg <= '0;
    end else if (done) begin
      res_reg <= ADC_DATA;
    end
  end

  // sticky flags: set wins over clear
  assign set_vec = {done && hit, done};
  assign clr_vec = ((wr && WB_ADR_I == adcc_pkg::ADDR_IRQCLR && WB_SEL_I[0])
    ? WB_DAT_I[1:0] : 2'h0)
    | {1'b0, rd && WB_ADR_I == adcc_pkg::ADDR_RESULT};
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      flag_reg <= 2'h0;
    end else if (CE) begin
      flag_reg <= set_vec | (flag_reg & ~clr_vec);
    end
  end

  // interrupt level and pin outputs, all registered
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_reg <= 1'b0;
      samp_en_reg <= 1'b0;
    end else if (CE) begin
      irq_reg <= |((set_vec | (flag_reg & ~clr_vec)) & irqen_reg);
      samp_en_reg <= sampling;
    end
  end

  // read data mux; unmapped addresses read zero
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_reg <= adcc_pkg::RESET_WORD;
    end else if (rd) begin
      unique case (WB_ADR_I)
        adcc_pkg::ADDR_CTRL: rdata_reg <= {30'h0, cap_reg, 1'b0};
        adcc_pkg::ADDR_SEL: rdata_reg <= {21'h0, ref_hold_reg, 3'h0, mux_hold_reg};
        adcc_pkg::ADDR_SAMP: rdata_reg <= {19'h0, len_reg, 4'h0, dly_reg};
        adcc_pkg::ADDR_WINCTL: rdata_reg <= {29'h0, wmode_reg};
        adcc_pkg::ADDR_WINLO: rdata_reg <= {22'h0, wlo_reg};
        adcc_pkg::ADDR_WINHI: rdata_reg <= {22'h0, whi_reg};
        adcc_pkg::ADDR_RESULT: rdata_reg <= {22'h0, res_reg};
        adcc_pkg::ADDR_STATUS: rdata_reg <= {23'h0, busy, 6'h0, flag_reg};
        adcc_pkg::ADDR_IRQEN: rdata_reg <= {30'h0, irqen_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;
  assign POSITIVE_INPUT_SELECT = mux_act_reg;
  assign REFERENCE_SELECT = ref_act_reg;
  assign SAMPLE_CAPACITANCE_SELECT = cap_reg;
  assign SAMPLE_EN = samp_en_reg;
  assign IRQ = irq_reg;

  // assertions
  sequence s_trig;
    trig_reg && CE;
  endsequence
  sequence s_sample_run;
    samp_en_reg;
  endsequence

  property p_start_next;
    @(posedge CLOCK) disable iff (RST) s_trig |=> busy;
  endproperty
  a_start_next: assert property (p_start_next) else $error("no start after trigger");

  // cycles spent sampling, counted only on enabled edges for the length check
  logic [7:0] samp_cnt_reg;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      samp_cnt_reg <= 8'h00;
    end else if (CE) begin
      samp_cnt_reg <= sampling ? samp_cnt_reg + 8'h01 : 8'h00;
    end
  end

  property p_samp_len;
    @(posedge CLOCK) disable iff (RST)
      $fell(sampling) |-> samp_cnt_reg == samp_cycles;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sample length wrong");

  property p_samp_two;
    @(posedge CLOCK) disable iff (RST)
      (CE && trig_reg && samp_cycles == 8'h02) ##1 CE ##1 CE |=> !sampling;
  endproperty
  a_samp_two: assert property (p_samp_two) else $error("two cycle sampling wrong");

  property p_lock;
    @(posedge CLOCK) disable iff (RST)
      (busy && !last) |=> $stable(mux_act_reg) && $stable(ref_act_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("selection changed while locked");

  property p_follow;
    @(posedge CLOCK) disable iff (RST)
      (CE && last && !trig_reg) |=> mux_act_reg == $past(mux_hold_reg);
  endproperty
  a_follow: assert property (p_follow) else $error("selection not copied at last");

  property p_idle_copy;
    @(posedge CLOCK) disable iff (RST)
      (CE && !busy && !trig_reg) |=> ref_act_reg == $past(ref_hold_reg);
  endproperty
  a_idle_copy: assert property (p_idle_copy) else $error("selection not copied idle");

  property p_rdy_set;
    @(posedge CLOCK) disable iff (RST) done |=> flag_reg[0];
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready flag not set");

  property p_rdy_clr;
    @(posedge CLOCK) disable iff (RST)
      (rd && WB_ADR_I == adcc_pkg::ADDR_RESULT && !done) |=> !flag_reg[0];
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared on read");

  property p_win;
    @(posedge CLOCK) disable iff (RST) (done && hit) |=> flag_reg[1];
  endproperty
  a_win: assert property (p_win) else $error("window flag not set");

  property p_irq_gate;
    @(posedge CLOCK) disable iff (RST) (CE && irqen_reg == 2'h0) |=> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
endmodule
`default_nettype wire

//--- tb_adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_control;
  // stimulus and observed signals
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [adcc_pkg::RES_W-1:0] ADC_DATA = '0;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic [adcc_pkg::MUX_W-1:0] POSITIVE_INPUT_SELECT;
  logic [adcc_pkg::REF_W-1:0] REFERENCE_SELECT;
  logic SAMPLE_CAPACITANCE_SELECT;
  logic SAMPLE_EN;
  logic IRQ;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rd;
  int samp;

  // 200 MHz clock
  always #2.5 CLOCK = ~CLOCK;

  adcc_top DUT (
    .CLOCK(CLOCK), .RST(RST), .CE(CE),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .ADC_DATA(ADC_DATA), .POSITIVE_INPUT_SELECT(POSITIVE_INPUT_SELECT),
    .REFERENCE_SELECT(REFERENCE_SELECT),
    .SAMPLE_CAPACITANCE_SELECT(SAMPLE_CAPACITANCE_SELECT),
    .SAMPLE_EN(SAMPLE_EN), .IRQ(IRQ)
  );

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge CLOCK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= dat;
    do begin
      @(posedge CLOCK);
    end while (WB_ACK_O !== 1'b1);
    check({31'h0, WB_ACK_O}, 32'h1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
  endtask

  // trigger one conversion, count sampling cycles, wait for completion
  task automatic convert(input logic [9:0] data);
    int n;
    ADC_DATA <= data;
    wb(1'b1, adcc_pkg::ADDR_CTRL, 32'h1);
    n = 0;
    while (SAMPLE_EN !== 1'b1 && n < 8) begin
      @(posedge CLOCK);
      n++;
    end
    check({31'h0, n <= 4}, 32'h1);
    samp = 0;
    while (SAMPLE_EN === 1'b1 && samp < 80) begin
      samp++;
      @(posedge CLOCK);
    end
    repeat (12) @(posedge CLOCK);
  endtask

  // reset values and unmapped space
  task automatic t_reset;
    check({POSITIVE_INPUT_SELECT, REFERENCE_SELECT, SAMPLE_EN, IRQ}, 32'h0);
    wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    wb(1'b0, 8'hfc, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask

  // sampling length, result read clears ready
  task automatic t_samp;
    logic [4:0] dl[3] = '{5'h0, 5'h3, 5'hf};
    logic [4:0] ln[3] = '{5'h0, 5'h4, 5'h1f};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, adcc_pkg::ADDR_SAMP, {19'h0, ln[i], 4'h0, dl[i][3:0]});
      convert(10'h2a5 + 10'(i));
      check(samp, 32'd2 + dl[i] + ln[i]);
      wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
      check({31'h0, rd[0]}, 32'h1);
      wb(1'b0, adcc_pkg::ADDR_RESULT, 32'h0);
      check(rd, 32'h2a5 + i);
      wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
      check({31'h0, rd[0]}, 32'h0);
    end
    $display("test sampling done");
  endtask

  // selection copy when idle, lock during conversion, release after
  task automatic t_lock;
    wb(1'b1, adcc_pkg::ADDR_SEL, 32'h0000_050a);
    repeat (3) @(posedge CLOCK);
    check({POSITIVE_INPUT_SELECT, REFERENCE_SELECT}, {5'h0a, 3'h5});
    wb(1'b1, adcc_pkg::ADDR_CTRL, 32'h1);
    wb(1'b1, adcc_pkg::ADDR_SEL, 32'h0000_0213);
    wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, rd[adcc_pkg::ST_BUSY_BIT]}, 32'h1);
    check({POSITIVE_INPUT_SELECT, REFERENCE_SELECT}, {5'h0a, 3'h5});
    repeat (70) @(posedge CLOCK);
    check({POSITIVE_INPUT_SELECT, REFERENCE_SELECT}, {5'h13, 3'h2});
    wb(1'b1, adcc_pkg::ADDR_SAMP, 32'h0);
    $display("test selection lock done");
  endtask

  // write-one clear of ready, ready interrupt raised and dropped
  task automatic t_ready;
    convert(10'h011);
    wb(1'b1, adcc_pkg::ADDR_IRQCLR, 32'h1);
    wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    wb(1'b1, adcc_pkg::ADDR_IRQEN, 32'h1);
    convert(10'h012);
    check({31'h0, IRQ}, 32'h1);
    wb(1'b0, adcc_pkg::ADDR_RESULT, 32'h0);
    wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, IRQ}, 32'h0);
    $display("test ready flag done");
  endtask

  // every window condition, masked and enabled interrupt
  task automatic t_window;
    logic [9:0] v[3] = '{10'd50, 10'd150, 10'd250};
    logic e;
    wb(1'b1, adcc_pkg::ADDR_WINLO, 32'd100);
    wb(1'b1, adcc_pkg::ADDR_WINHI, 32'd200);
    for (int en = 0; en < 2; en++) begin
      wb(1'b1, adcc_pkg::ADDR_IRQEN, {30'h0, en[0], 1'b0});
      for (int m = 0; m < 5; m++) begin
        wb(1'b1, adcc_pkg::ADDR_WINCTL, 32'(m));
        for (int i = 0; i < 3; i++) begin
          convert(v[i]);
          e = (m == 1) ? v[i] < 100 : (m == 2) ? v[i] > 200 :
              (m == 3) ? (v[i] > 100 && v[i] < 200) :
              (m == 4) ? (v[i] < 100 || v[i] > 200) : 1'b0;
          wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
          check({30'h0, rd[1:0]}, {30'h0, e, 1'b1});
          check({31'h0, IRQ}, {31'h0, e & en[0]});
          wb(1'b1, adcc_pkg::ADDR_IRQCLR, 32'h3);
          wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
          check({29'h0, rd[1:0], IRQ}, 32'h0);
        end
      end
    end
    $display("test window done");
  endtask

  // clock enable low freezes the sequencer in mid-sample
  task automatic t_freeze;
    wb(1'b1, adcc_pkg::ADDR_CTRL, 32'h1);
    @(posedge CLOCK);
    CE <= 1'b0;
    repeat (6) @(posedge CLOCK);
    check({31'h0, SAMPLE_EN}, 32'h1);
    CE <= 1'b1;
    repeat (3) @(posedge CLOCK);
    check({31'h0, SAMPLE_EN}, 32'h0);
    repeat (12) @(posedge CLOCK);
    wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h1);
    wb(1'b0, adcc_pkg::ADDR_RESULT, 32'h0);
    check(rd, 32'h012);
    $display("test clock enable done");
  endtask

  // capacitance select bit reaches its pin
  task automatic t_cap;
    wb(1'b1, adcc_pkg::ADDR_CTRL, 32'h2);
    wb(1'b0, adcc_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, SAMPLE_CAPACITANCE_SELECT}, 32'h1);
    $display("test capacitance done");
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset();
    t_samp();
    t_lock();
    t_ready();
    t_freeze();
    t_window();
    t_cap();
    summarize();
  end

  // watchdog
  initial begin
    #100us;
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
